// *** rtl/power_down_mode_control.sv ***
/*
  Power-down mode control: system control and module standby registers on APB,
  sleep / software standby / hardware standby sequencing, clock and module gating.
  Assumes the cpu pulses sleep_exec on pclk when its sleep instruction completes,
  and that interrupt enables and masks arrive as levels from the same clock domain.
*/
// Local design decision: register access over APB.
// How it works
// - standby select 0 makes the sleep instruction enter sleep mode.
// - standby select 1 makes the sleep instruction enter software standby.
// - interrupt exit leaves standby select at 1; a software write, the reset pin or the standby pin clears it.
// - settle select codes pick 8192..131072 or 1024 states; 11x illegal.
// - module standby register loads 0x40 on reset and hardware standby only.
// - clock output stop bit 0 passes the system clock out, 1 blocks it.
// - module standby bit 6 is reserved, reads 1, ignores writes.
// - module standby bits 5..0 halt timer, serial 0/1, dma, refresh, converter.
// - cpu halts right after the sleep instruction and keeps its registers.
// - in sleep, dma, refresh and peripherals keep running on the clock.
// - peripherals with standby bit set stay halted through sleep mode.
// - an accepted interrupt ends sleep and starts interrupt handling.
// - a peripheral interrupt disabled in its peripheral does not wake sleep.
// - masked non-nmi interrupts do not wake the device from sleep.
// - reset pin low during sleep moves the device to reset state.
// - standby pin low during sleep moves the device to hardware standby.
// - setting a module standby bit resets that peripheral's registers.
// - interrupt exit from software standby restarts oscillator, waits, then runs.
`timescale 1ns/1ps
`include "pdm_cfg.svh"

module power_down_mode_control #(
  parameter logic [`PDM_CNT_W-1:0] SETTLE_0 = `PDM_SETTLE_0,
  parameter logic [`PDM_CNT_W-1:0] SETTLE_1 = `PDM_SETTLE_1,
  parameter logic [`PDM_CNT_W-1:0] SETTLE_2 = `PDM_SETTLE_2,
  parameter logic [`PDM_CNT_W-1:0] SETTLE_3 = `PDM_SETTLE_3,
  parameter logic [`PDM_CNT_W-1:0] SETTLE_4 = `PDM_SETTLE_4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire pdm_pkg::apb_req_type apb_req,
  output pdm_pkg::apb_rsp_type apb_rsp,
  input wire logic sleep_exec,
  input wire logic reset_in_n,
  input wire logic standby_in_n,
  input wire logic nmi_in,
  input wire logic [`PDM_EXT_IRQ_W-1:0] ext_irq_n,
  input wire logic [`PDM_EXT_IRQ_W-1:0] ext_irq_en,
  input wire logic [`PDM_EXT_IRQ_W-1:0] ext_irq_masked,
  input wire logic [`PDM_IRQ_W-1:0] periph_irq_req,
  input wire logic [`PDM_IRQ_W-1:0] periph_irq_en,
  input wire logic [`PDM_IRQ_W-1:0] periph_irq_masked,
  output logic cpu_halt,
  output logic osc_run,
  output logic chip_clock_en,
  output logic clock_out_en,
  output logic chip_reset,
  output logic hw_standby,
  output logic irq_exception,
  output logic [`PDM_MOD_W-1:0] module_clock_en,
  output logic [`PDM_MOD_W-1:0] module_reset
);

  // ==========================================================================
  // addresses
  localparam logic [`PDM_ADDR_W-1:0] MOD_STANDBY_ADDR = {`PDM_MOD_STANDBY_IDX, 2'b00};
  localparam logic [`PDM_ADDR_W-1:0] SYS_CONTROL_ADDR = {`PDM_SYS_CONTROL_IDX, 2'b00};
  localparam logic [`PDM_ADDR_W-1:0] STATUS_ADDR = {`PDM_STATUS_IDX, 2'b00};

  pdm_pkg::power_state_type state_q;
  pdm_pkg::power_state_type state_d;
  logic [7:0] sys_control_q;
  logic [7:0] mod_standby_q;
  logic [31:0] prdata_q;
  logic exc_q;
  logic [`PDM_PIN_W-1:0] pins_q;
  logic rst_pin;
  logic standby_pin;
  logic nmi;
  logic [`PDM_EXT_IRQ_W-1:0] ext_irq;
  logic ext_wake;
  logic sleep_wake;
  logic settle_load;
  logic settle_busy;
  logic settle_done;
  logic setup;
  logic access;
  logic wr_en;
  logic mapped;
  logic standby_select;
  logic clock_output_stop;
  logic [2:0] sts;
  logic [`PDM_MOD_W-1:0] mstop;

  // ==========================================================================
  // pin synchronisers
  pin_sync u_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pins({ext_irq_n, nmi_in, standby_in_n, reset_in_n}),
    .pins_q(pins_q)
  );

  assign rst_pin = !pins_q[0];
  assign standby_pin = !pins_q[1];
  assign nmi = pins_q[2];
  assign ext_irq = ~pins_q[5:3];

  // field views of the registers
  assign standby_select = sys_control_q[`PDM_SELECT_BIT];
  assign sts = sys_control_q[`PDM_STS_MSB:`PDM_STS_LSB];
  assign clock_output_stop = mod_standby_q[`PDM_CLK_STOP_BIT];
  assign mstop = mod_standby_q[`PDM_MSTOP_MSB:0];

  // ==========================================================================
  // wake conditions; masks and enables come from the cpu and peripherals
  // software standby only hears nmi and the external pins
  assign ext_wake = nmi || |(ext_irq & ext_irq_en & ~ext_irq_masked);
  // a disabled or masked source never reaches the wake term
  assign sleep_wake = ext_wake
    || |(periph_irq_req & periph_irq_en & ~periph_irq_masked);

  // ==========================================================================
  // apb slave: zero wait, read data captured in the setup cycle
  assign setup = apb_req.psel && !apb_req.penable;
  assign access = apb_req.psel && apb_req.penable;
  assign mapped = (apb_req.paddr == MOD_STANDBY_ADDR) || (apb_req.paddr == SYS_CONTROL_ADDR)
    || (apb_req.paddr == STATUS_ADDR);
  assign wr_en = access && apb_req.pwrite && mapped;
  assign apb_rsp.prdata = prdata_q;
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = access && !mapped;

  // read mux; unmapped addresses read zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (setup && !apb_req.pwrite) begin
      if (apb_req.paddr == MOD_STANDBY_ADDR) begin
        prdata_q <= {24'h000000, mod_standby_q};
      end else if (apb_req.paddr == SYS_CONTROL_ADDR) begin
        prdata_q <= {24'h000000, sys_control_q};
      end else if (apb_req.paddr == STATUS_ADDR) begin
        prdata_q <= {27'h0000000, clock_out_en, settle_busy, state_q};
      end else begin
        prdata_q <= '0;
      end
    end
  end

  // ==========================================================================
  // system control register; wake never touches standby select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_control_q <= `PDM_SYS_CONTROL_RST;
    end else if (rst_pin || standby_pin) begin
      sys_control_q <= `PDM_SYS_CONTROL_RST;
    end else if (wr_en && apb_req.paddr == SYS_CONTROL_ADDR) begin
      sys_control_q <= apb_req.pwdata[7:0];
    end
  end

  // module standby register: kept through software standby
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mod_standby_q <= `PDM_MOD_STANDBY_RST;
    end else if (rst_pin || standby_pin) begin
      mod_standby_q <= `PDM_MOD_STANDBY_RST;
    end else if (wr_en && apb_req.paddr == MOD_STANDBY_ADDR) begin
      mod_standby_q <= apb_req.pwdata[7:0] | `PDM_MOD_STANDBY_RST;
    end
  end

  // ==========================================================================
  // power state machine; standby pin wins over reset pin, both over wake
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      pdm_pkg::st_run: begin
        if (sleep_exec) begin
          state_d = standby_select ? pdm_pkg::st_sw_standby : pdm_pkg::st_sleep;
        end
      end
      pdm_pkg::st_sleep: begin
        if (sleep_wake) begin
          state_d = pdm_pkg::st_run;
        end
      end
      pdm_pkg::st_sw_standby: begin
        if (ext_wake) begin
          state_d = pdm_pkg::st_settle;
        end
      end
      pdm_pkg::st_settle: begin
        if (settle_done) begin
          state_d = pdm_pkg::st_run;
        end
      end
      pdm_pkg::st_hw_standby: begin
        state_d = pdm_pkg::st_run;
      end
      default: state_d = pdm_pkg::st_run;
    endcase
    if (standby_pin) begin
      state_d = pdm_pkg::st_hw_standby;
    end else if (rst_pin) begin
      state_d = pdm_pkg::st_run;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= pdm_pkg::st_run;
    end else begin
      state_q <= state_d;
    end
  end

  // one-cycle start of interrupt handling on every interrupt exit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exc_q <= 1'b0;
    end else begin
      exc_q <= (state_d == pdm_pkg::st_run) && !standby_pin && !rst_pin
        && ((state_q == pdm_pkg::st_sleep) || (state_q == pdm_pkg::st_settle));
    end
  end

  // ==========================================================================
  // oscillator settling
  assign settle_load = (state_q == pdm_pkg::st_sw_standby) && (state_d == pdm_pkg::st_settle);

  settle_timer #(
    .SETTLE_0(SETTLE_0),
    .SETTLE_1(SETTLE_1),
    .SETTLE_2(SETTLE_2),
    .SETTLE_3(SETTLE_3),
    .SETTLE_4(SETTLE_4)
  ) u_settle (
    .pclk(pclk),
    .presetn(presetn),
    .load(settle_load),
    .sel(sts),
    .busy(settle_busy),
    .done(settle_done)
  );

  // ==========================================================================
  // clock, halt and module controls
  // the cpu halts in every low-power state; registers untouched except in hardware standby, which asserts chip_reset
  assign cpu_halt = (state_q != pdm_pkg::st_run);
  assign osc_run = (state_q != pdm_pkg::st_sw_standby) && (state_q != pdm_pkg::st_hw_standby);
  assign chip_clock_en = (state_q == pdm_pkg::st_run) || (state_q == pdm_pkg::st_sleep);
  assign clock_out_en = chip_clock_en && !clock_output_stop;
  assign hw_standby = (state_q == pdm_pkg::st_hw_standby);
  assign chip_reset = rst_pin || hw_standby;
  assign irq_exception = exc_q;

  // sleep keeps modules clocked; standby bits stop them regardless of state
  assign module_clock_en = {`PDM_MOD_W{chip_clock_en}} & ~mstop;

  // set bit holds the module in reset; software standby resets all but refresh
  always_comb begin
    module_reset = mstop;
    if (chip_reset) begin
      module_reset = {`PDM_MOD_W{1'b1}};
    end else if ((state_q == pdm_pkg::st_sw_standby) || (state_q == pdm_pkg::st_settle)) begin
      module_reset = mstop | `PDM_SWSTBY_RST_MASK;
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sleep_entry_a: assert property (
    state_q == pdm_pkg::st_run && sleep_exec && !standby_select && !standby_pin && !rst_pin
    |=> state_q == pdm_pkg::st_sleep && cpu_halt && chip_clock_en)
    else $error("sleep instruction with select 0 did not enter sleep");

  swstby_entry_a: assert property (
    state_q == pdm_pkg::st_run && sleep_exec && standby_select && !standby_pin && !rst_pin
    |=> state_q == pdm_pkg::st_sw_standby && !osc_run)
    else $error("sleep instruction with select 1 did not enter software standby");

  select_kept_a: assert property (
    !(wr_en && apb_req.paddr == SYS_CONTROL_ADDR) && !rst_pin && !standby_pin
    |=> $stable(standby_select))
    else $error("standby select changed without a write");

  mod_standby_init_a: assert property (
    standby_pin |=> mod_standby_q == `PDM_MOD_STANDBY_RST
      ##1 (state_q == pdm_pkg::st_hw_standby || !standby_pin))
    else $error("module standby register not initialised by hardware standby");

  clock_out_a: assert property (
    chip_clock_en |-> clock_out_en == !clock_output_stop)
    else $error("clock output does not follow its stop bit");

  reserved_one_a: assert property (
    mod_standby_q[`PDM_RSVD_BIT])
    else $error("reserved standby bit not held at one");

  reserved_read_a: assert property (
    setup && !apb_req.pwrite && apb_req.paddr == MOD_STANDBY_ADDR
    |=> prdata_q[`PDM_RSVD_BIT])
    else $error("reserved standby bit not read as one");

  sleep_mods_a: assert property (
    state_q == pdm_pkg::st_sleep |-> (module_clock_en & mstop) == '0
      && module_clock_en == ~mstop)
    else $error("module clocking wrong in sleep");

  sleep_wake_a: assert property (
    state_q == pdm_pkg::st_sleep && sleep_wake && !standby_pin && !rst_pin
    |=> state_q == pdm_pkg::st_run && irq_exception ##1 !irq_exception)
    else $error("accepted interrupt did not end sleep");

  masked_stay_a: assert property (
    state_q == pdm_pkg::st_sleep && !sleep_wake && !standby_pin && !rst_pin
    |=> state_q == pdm_pkg::st_sleep)
    else $error("sleep ended without an accepted interrupt");

  reset_pin_a: assert property (
    state_q == pdm_pkg::st_sleep && rst_pin && !standby_pin
    |-> chip_reset ##1 state_q == pdm_pkg::st_run && !irq_exception)
    else $error("reset pin did not end sleep in reset");

  standby_pin_a: assert property (
    standby_pin |=> hw_standby && (module_reset == {`PDM_MOD_W{1'b1}}))
    else $error("standby pin did not enter hardware standby");

  settle_exit_a: assert property (
    settle_load |=> state_q == pdm_pkg::st_settle && settle_busy && !chip_clock_en)
    else $error("interrupt exit from software standby skipped settling");

endmodule // power_down_mode_control

// *** rtl/pdm_cfg.svh ***
/*
  Constants of the power-down mode control block: register indices, reset values,
  field positions and settling counts.
  Assumes it is included by bare name from the package and the design files.
*/
`ifndef PDM_CFG_SVH
`define PDM_CFG_SVH

// ==========================================================================
// register map (index; byte address is four times the index)
`define PDM_ADDR_W 18
`define PDM_MOD_STANDBY_IDX 16'hFF5E
`define PDM_SYS_CONTROL_IDX 16'hFFF2
`define PDM_STATUS_IDX 16'hFF00

// ==========================================================================
// reset values and field positions
`define PDM_MOD_STANDBY_RST 8'h40
`define PDM_SYS_CONTROL_RST 8'h0B
`define PDM_SELECT_BIT 7
`define PDM_STS_MSB 6
`define PDM_STS_LSB 4
`define PDM_CLK_STOP_BIT 7
`define PDM_RSVD_BIT 6
`define PDM_MSTOP_MSB 5
`define PDM_MOD_W 6
`define PDM_SWSTBY_RST_MASK 6'h3D

// ==========================================================================
// settling waits in states (one state is one pclk cycle)
`define PDM_SETTLE_0 8192
`define PDM_SETTLE_1 16384
`define PDM_SETTLE_2 32768
`define PDM_SETTLE_3 65536
`define PDM_SETTLE_4 131072
`define PDM_SETTLE_5 1024
`define PDM_CNT_W 18

// ==========================================================================
// pins and interrupt widths
`define PDM_PIN_W 6
`define PDM_PIN_RST 6'h3B
`define PDM_IRQ_W 8
`define PDM_EXT_IRQ_W 3

`endif

// *** rtl/pdm_pkg.sv ***
/*
  Types of the power-down mode control block: power states and APB carriers.
  Assumes pdm_cfg.svh is on the include path.
*/
`include "pdm_cfg.svh"

package pdm_pkg;

  // ==========================================================================
  // power states
  typedef enum logic [2:0] {
    st_run = 3'b000,
    st_sleep = 3'b001,
    st_sw_standby = 3'b010,
    st_settle = 3'b011,
    st_hw_standby = 3'b100
  } power_state_type;

  // ==========================================================================
  // apb request and response
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [`PDM_ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_type;

endpackage

// *** rtl/pin_sync.sv ***
/*
  Three-stage synchroniser for a bundle of asynchronous pins.
  Assumes one clock pclk; a change is accepted once stages two and three agree.
*/
`timescale 1ns/1ps
`include "pdm_cfg.svh"

module pin_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [`PDM_PIN_W-1:0] pins,
  output logic [`PDM_PIN_W-1:0] pins_q
);

  logic [`PDM_PIN_W-1:0] s1_q;
  logic [`PDM_PIN_W-1:0] s2_q;
  logic [`PDM_PIN_W-1:0] s3_q;

  // ==========================================================================
  // stage one feeds stage two only, so no metastable value reaches logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= `PDM_PIN_RST;
      s2_q <= `PDM_PIN_RST;
      s3_q <= `PDM_PIN_RST;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // accept each bit only when the last two stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_q <= `PDM_PIN_RST;
    end else begin
      for (int i = 0; i < `PDM_PIN_W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          pins_q[i] <= s3_q[i];
        end
      end
    end
  end

endmodule // pin_sync

// *** rtl/settle_timer.sv ***
/*
  Oscillator settling counter: loads a wait from the settle select code and
  counts system clock states down to zero.
  Assumes load is a one-cycle pulse on pclk.
*/
`timescale 1ns/1ps
`include "pdm_cfg.svh"

module settle_timer #(
  parameter logic [`PDM_CNT_W-1:0] SETTLE_0 = `PDM_SETTLE_0,
  parameter logic [`PDM_CNT_W-1:0] SETTLE_1 = `PDM_SETTLE_1,
  parameter logic [`PDM_CNT_W-1:0] SETTLE_2 = `PDM_SETTLE_2,
  parameter logic [`PDM_CNT_W-1:0] SETTLE_3 = `PDM_SETTLE_3,
  parameter logic [`PDM_CNT_W-1:0] SETTLE_4 = `PDM_SETTLE_4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [2:0] sel,
  output logic busy,
  output logic done
);

  logic [`PDM_CNT_W-1:0] cnt_q;
  logic busy_q;

  // illegal codes 11x take the longest wait, the safe side for a crystal
  function automatic logic [`PDM_CNT_W-1:0] wait_of(input logic [2:0] code);
    unique case (code)
      3'h0: wait_of = SETTLE_0;
      3'h1: wait_of = SETTLE_1;
      3'h2: wait_of = SETTLE_2;
      3'h3: wait_of = SETTLE_3;
      3'h4: wait_of = SETTLE_4;
      3'h5: wait_of = `PDM_CNT_W'(`PDM_SETTLE_5);
      default: wait_of = SETTLE_4;
    endcase
  endfunction

  // ==========================================================================
  // count: done pulses after exactly wait_of(sel) states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
    end else if (load) begin
      cnt_q <= wait_of(sel) - `PDM_CNT_W'(1);
      busy_q <= 1'b1;
    end else if (busy_q) begin
      if (cnt_q == '0) begin
        busy_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q - `PDM_CNT_W'(1);
      end
    end
  end

  assign busy = busy_q;
  assign done = busy_q && (cnt_q == '0);

  settle_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    load |=> busy && cnt_q == wait_of($past(sel)) - `PDM_CNT_W'(1))
    else $error("settle counter not loaded from select code");

endmodule // settle_timer

// *** tb/cpu_model.sv ***
/*
  Behavioural cpu front end: issues the sleep instruction and counts
  interrupt exception entries.
  Assumes the bench raises sleep_req as a level; at most one pulse per rising level, none while halted.
*/
`timescale 1ns/1ps

// ==========================================================================
// cpu model
module cpu_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sleep_req,
  input wire logic cpu_halt,
  input wire logic irq_exception,
  output logic sleep_exec,
  output logic [7:0] exc_count
);
  logic req_q;

  // a halted cpu cannot run the sleep instruction, so no pulse while halted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_q <= 1'b0;
      sleep_exec <= 1'b0;
      exc_count <= 8'h00;
    end else begin
      req_q <= sleep_req;
      sleep_exec <= sleep_req & ~req_q & ~cpu_halt;
      if (irq_exception) begin
        exc_count <= exc_count + 8'h01;
      end
    end
  end
endmodule // cpu_model

// *** tb/tb.sv ***
/*
  Self-checking bench of the power-down mode control block.
  Assumes short settling parameters; registers reached over APB only.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

// ==========================================================================
// bench top
module tb;
  localparam logic [17:0] a_mst = 18'h3FD78;
  localparam logic [17:0] a_sys = 18'h3FFC8;
  localparam logic [17:0] a_stat = 18'h3FC00;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  pdm_pkg::apb_req_type req;
  pdm_pkg::apb_rsp_type rsp;
  logic sleep_req, sleep_exec, reset_in_n, standby_in_n, nmi_in, er;
  logic [2:0] ext_irq_n, ext_irq_en, ext_irq_masked;
  logic [7:0] periph_irq_req, periph_irq_en, periph_irq_masked, exc_count, e;
  logic cpu_halt, osc_run, chip_clock_en, clock_out_en, chip_reset, hw_standby, irq_exception;
  logic [5:0] module_clock_en, module_reset;
  logic [31:0] rd;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  int w[6] = '{16, 32, 64, 128, 256, 1024};

  power_down_mode_control #(.SETTLE_0(18'h10), .SETTLE_1(18'h20), .SETTLE_2(18'h40),
    .SETTLE_3(18'h80), .SETTLE_4(18'h100)) power_down_mode_control_i (.pclk(pclk),
    .presetn(presetn), .apb_req(req), .apb_rsp(rsp), .sleep_exec(sleep_exec),
    .reset_in_n(reset_in_n), .standby_in_n(standby_in_n), .nmi_in(nmi_in),
    .ext_irq_n(ext_irq_n), .ext_irq_en(ext_irq_en), .ext_irq_masked(ext_irq_masked),
    .periph_irq_req(periph_irq_req), .periph_irq_en(periph_irq_en),
    .periph_irq_masked(periph_irq_masked), .cpu_halt(cpu_halt), .osc_run(osc_run),
    .chip_clock_en(chip_clock_en), .clock_out_en(clock_out_en), .chip_reset(chip_reset),
    .hw_standby(hw_standby), .irq_exception(irq_exception),
    .module_clock_en(module_clock_en), .module_reset(module_reset));

  cpu_model cpu_model_i (.pclk(pclk), .presetn(presetn), .sleep_req(sleep_req),
    .cpu_halt(cpu_halt), .irq_exception(irq_exception), .sleep_exec(sleep_exec),
    .exc_count(exc_count));

  // clock and hang guard; the longest wait is about 1100 cycles
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end

  task final_report;
    $display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // settle point one nanosecond after an edge, clear of the edge updates
  task t(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  // one apb transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] d);
    @(posedge pclk);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge pclk);
    req.penable <= 1'b1;
    // only the bench timeout ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic sleep_go;
    int n = 0;
    @(posedge pclk) sleep_req <= 1'b1;
    do begin
      t(1);
      n++;
    end while (cpu_halt !== 1'b1 && n < 10);
    `CHK(cpu_halt, 1'b1)
    @(posedge pclk) sleep_req <= 1'b0;
  endtask

  // ==========================================================================
  // scenarios
  task t_reset;
    t(1);
    `CHK(module_clock_en, 6'h3F)
    `CHK(clock_out_en, 1'b1)
    apb(1'b0, a_mst, 32'h0);
    `CHK(rd, 32'h40)
    apb(1'b0, a_sys, 32'h0);
    `CHK(rd, 32'h0B)
    apb(1'b0, 18'h00004, 32'h0);
    `CHK(er, 1'b1)
  endtask

  task t_regs;
    apb(1'b1, a_mst, 32'h0);
    apb(1'b0, a_mst, 32'h0);
    `CHK(rd, 32'h40)
    apb(1'b1, a_mst, 32'hBF);
    apb(1'b0, a_mst, 32'h0);
    `CHK(rd, 32'hFF)
    t(1);
    `CHK(clock_out_en, 1'b0)
    `CHK(module_reset, 6'h3F)
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, a_mst, 32'h1 << i);
      t(1);
      `CHK(module_clock_en, ~(6'h01 << i))
    end
  endtask

  task t_sleep;
    apb(1'b1, a_mst, 32'h20);
    sleep_go();
    apb(1'b0, a_stat, 32'h0);
    `CHK(rd[2:0], 3'h1)
    `CHK({osc_run, chip_clock_en}, 2'h3)
    `CHK(module_clock_en, 6'h1F)
    @(posedge pclk) periph_irq_en <= 8'hFE;
    periph_irq_req <= 8'h01;
    t(8);
    `CHK(cpu_halt, 1'b1)
    @(posedge pclk) periph_irq_en <= 8'hFF;
    periph_irq_masked <= 8'h01;
    t(8);
    `CHK(cpu_halt, 1'b1)
    e = exc_count;
    @(posedge pclk) nmi_in <= 1'b1;
    t(8);
    `CHK({cpu_halt, exc_count}, {1'b0, e + 8'h01})
    @(posedge pclk) nmi_in <= 1'b0;
    periph_irq_req <= 8'h00;
    periph_irq_masked <= 8'h00;
    // let the synchronised nmi fall first, or it would end the next sleep at once
    t(8);
    sleep_go();
    @(posedge pclk) periph_irq_req <= 8'h80;
    t(2);
    `CHK(cpu_halt, 1'b0)
    @(posedge pclk) periph_irq_req <= 8'h00;
  endtask

  task automatic t_swstby;
    int n;
    apb(1'b1, a_mst, 32'h44);
    for (int c = 0; c < 6; c++) begin
      apb(1'b1, a_sys, {24'h0, 1'b1, c[2:0], 4'hB});
      sleep_go();
      `CHK(osc_run, 1'b0)
      @(posedge pclk) ext_irq_n <= 3'b110;
      n = 0;
      do begin
        t(1);
        n++;
      end while (cpu_halt === 1'b1 && n < 3000);
      `CHK((n >= w[c]) && (n <= w[c] + 8), 1'b1)
      @(posedge pclk) ext_irq_n <= 3'b111;
      apb(1'b0, a_sys, 32'h0);
      `CHK(rd, {24'h0, 1'b1, c[2:0], 4'hB})
    end
    apb(1'b0, a_mst, 32'h0);
    `CHK(rd, 32'h44)
    apb(1'b1, a_sys, 32'h0B);
    apb(1'b0, a_sys, 32'h0);
    `CHK(rd, 32'h0B)
  endtask

  task t_pins;
    apb(1'b1, a_mst, 32'h7F);
    sleep_go();
    @(posedge pclk) reset_in_n <= 1'b0;
    t(8);
    `CHK({chip_reset, cpu_halt}, 2'h2)
    @(posedge pclk) reset_in_n <= 1'b1;
    t(8);
    apb(1'b0, a_mst, 32'h0);
    `CHK(rd, 32'h40)
    apb(1'b1, a_mst, 32'h41);
    sleep_go();
    @(posedge pclk) standby_in_n <= 1'b0;
    t(8);
    `CHK({hw_standby, chip_clock_en}, 2'h2)
    @(posedge pclk) standby_in_n <= 1'b1;
    t(8);
    apb(1'b0, a_mst, 32'h0);
    `CHK(rd, 32'h40)
  endtask

  // main sequence; every input driven from time zero
  initial begin
    req = '0;
    {sleep_req, nmi_in, reset_in_n, standby_in_n} = 4'h3;
    {ext_irq_n, ext_irq_en, ext_irq_masked} = 9'h1F8;
    {periph_irq_req, periph_irq_en, periph_irq_masked} = 24'h00FF00;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_regs();
    t_sleep();
    t_swstby();
    t_pins();
    final_report();
  end
endmodule // tb
